/* edsc_top.sv */
// How it works
// - Sleep needs mode 1 or 4 plus request or idle
// - Idle time without traffic triggers sleep in mode 4
// - Mode zero never sleeps, always ready
// - Mode 1: pin high sleeps, low wakes
// - Finish ongoing transfer before sleeping
// - Pin sleep ignores serial and radio activity
// - Clear-to-send low marks ready after wake
// - Pin wake polls parent, keeps polling awake
// - Mode 4 sleeps one configured period
// - Period expiry wakes, checks serial, polls
// - Stay awake if parent data, else sleep
// - Activity starts and restarts idle timer
// - Awake cyclic mode keeps polling parent
// - Awake indicator asserted on each unsuppressed wake
// - Suppress count hides indicator across mode 4 wakes
// - Flow control: cts low awake, high asleep
// - Only end-device role may sleep
`timescale 1ns/1ps
`default_nettype none
module edsc_top
   import edsc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sleep_request_pin,
   input  wire logic        xfer_busy,
   input  wire logic        serial_activity,
   input  wire logic        radio_activity,
   input  wire logic        parent_has_data,
   output logic             poll_req,
   output logic             awake_indicator,
   output logic             cts_n,
   output logic             low_power
);
   typedef struct packed {
      logic [2:0]  mode;
      logic [1:0]  role;
      logic        cts_en;
      logic [15:0] idle_time;
      logic [15:0] period;
      logic [15:0] supp;
      logic [15:0] poll_iv;
      edsc_state_e state;
      logic [15:0] idle_cnt;
      logic [15:0] sleep_cnt;
      logic [15:0] poll_cnt;
      logic [15:0] supp_cnt;
      logic        pin_s1;
      logic        pin_s2;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        poll_req;
      logic        awake_ind;
      logic        cts_n;
      logic        low_power;
   } edsc_top_s;

   edsc_top_s st_ff;
   edsc_top_s nxt_st;
   logic      tick;

   edsc_tick u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   logic        acc;
   logic        wr_en;
   logic        can_sleep;
   logic        activity;
   logic        idle_done;
   logic        sleep_go;
   logic        wake_now;
   logic        sup_hide;

   always_comb begin
      nxt_st = st_ff;
      acc = psel && penable && !st_ff.pready;
      // Pin seen only through two flops
      nxt_st.pin_s1 = sleep_request_pin;
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.pready = acc;
      nxt_st.pslverr = 1'b0;
      nxt_st.poll_req = 1'b0;
      wake_now = 1'b0;
      sleep_go = 1'b0;

      // APB slave, one wait state; read word and error decoded on first access edge
      if (acc) begin
         nxt_st.prdata = 32'h0;
         unique case (paddr)
            ADDR_MODE: begin
               nxt_st.prdata[MODE_SEL_LSB +: 3] = st_ff.mode;
               nxt_st.prdata[MODE_ROLE_LSB +: 2] = st_ff.role;
               nxt_st.prdata[MODE_CTS_BIT] = st_ff.cts_en;
            end
            ADDR_IDLE: begin
               nxt_st.prdata[15:0] = st_ff.idle_time;
            end
            ADDR_PERIOD: begin
               nxt_st.prdata[15:0] = st_ff.period;
            end
            ADDR_SUPP: begin
               nxt_st.prdata[15:0] = st_ff.supp;
            end
            ADDR_POLLIV: begin
               nxt_st.prdata[15:0] = st_ff.poll_iv;
            end
            ADDR_STATUS: begin
               nxt_st.prdata[3:0] = st_ff.state;
               nxt_st.prdata[4] = st_ff.low_power;
               nxt_st.prdata[5] = st_ff.awake_ind;
               nxt_st.prdata[6] = st_ff.cts_n;
               nxt_st.pslverr = pwrite;
            end
            default: begin
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end

      // Writes land only at the edge that completes the transfer
      wr_en = psel && penable && pwrite && st_ff.pready;
      if (wr_en) begin
         unique case (paddr)
            ADDR_MODE: begin
               nxt_st.mode = pwdata[MODE_SEL_LSB +: 3];
               nxt_st.role = pwdata[MODE_ROLE_LSB +: 2];
               nxt_st.cts_en = pwdata[MODE_CTS_BIT];
            end
            ADDR_IDLE: begin
               nxt_st.idle_time = pwdata[15:0];
            end
            ADDR_PERIOD: begin
               nxt_st.period = pwdata[15:0];
            end
            ADDR_SUPP: begin
               nxt_st.supp = pwdata[15:0];
            end
            ADDR_POLLIV: begin
               nxt_st.poll_iv = pwdata[15:0];
            end
            default: begin
               // Status is read only; holes take nothing
            end
         endcase
      end

      can_sleep = (st_ff.mode == SLEEP_MODE_PIN || st_ff.mode == SLEEP_MODE_CYCLIC)
                  && st_ff.role == ROLE_END;
      activity = serial_activity || radio_activity || xfer_busy;
      idle_done = st_ff.idle_cnt >= st_ff.idle_time;

      // Idle timer in base ticks, restarted by any traffic
      if (activity || st_ff.state == EDSC_ASLEEP) begin
         nxt_st.idle_cnt = 16'h0;
      end else if (tick && !idle_done) begin
         nxt_st.idle_cnt = st_ff.idle_cnt + 16'h1;
      end

      unique case (st_ff.state)
         EDSC_AWAKE: begin
            if (st_ff.mode == SLEEP_MODE_PIN) begin
               if (st_ff.pin_s2 && can_sleep) begin
                  nxt_st.state = EDSC_DRAIN;
               end
            end else if (st_ff.mode == SLEEP_MODE_CYCLIC && can_sleep && idle_done) begin
               nxt_st.state = EDSC_DRAIN;
            end
         end
         EDSC_DRAIN: begin
            // Let the transfer in flight finish first
            if (!can_sleep) begin
               nxt_st.state = EDSC_AWAKE;
            end else if (!xfer_busy) begin
               sleep_go = 1'b1;
            end
         end
         EDSC_ASLEEP: begin
            // Serial and radio inputs are not looked at here
            if (!can_sleep) begin
               wake_now = 1'b1;
            end else if (st_ff.mode == SLEEP_MODE_PIN) begin
               if (!st_ff.pin_s2) begin
                  wake_now = 1'b1;
               end
            end else if (tick) begin
               if (st_ff.sleep_cnt + 16'h1 >= st_ff.period) begin
                  wake_now = 1'b1;
               end else begin
                  nxt_st.sleep_cnt = st_ff.sleep_cnt + 16'h1;
               end
            end
         end
         EDSC_CHECK: begin
            // One poll went out on wake; wait one poll interval for answer
            if (!can_sleep || parent_has_data || activity || st_ff.mode != SLEEP_MODE_CYCLIC) begin
               nxt_st.state = EDSC_AWAKE;
               nxt_st.idle_cnt = 16'h0;
            end else if (tick && st_ff.poll_cnt >= st_ff.poll_iv) begin
               sleep_go = 1'b1;
            end
         end
         default: begin
            nxt_st.state = EDSC_AWAKE;
         end
      endcase

      // Suppression window: count wakes, show indicator only at limit
      sup_hide = st_ff.mode == SLEEP_MODE_CYCLIC && st_ff.supp != 16'h0
                 && st_ff.supp_cnt + 16'h1 < st_ff.supp;

      if (sleep_go) begin
         nxt_st.state = EDSC_ASLEEP;
         nxt_st.sleep_cnt = 16'h0;
         nxt_st.low_power = 1'b1;
         nxt_st.awake_ind = 1'b0;
         nxt_st.cts_n = 1'b1;
      end
      if (wake_now) begin
         nxt_st.state = (st_ff.mode == SLEEP_MODE_CYCLIC) ? EDSC_CHECK : EDSC_AWAKE;
         nxt_st.low_power = 1'b0;
         nxt_st.cts_n = 1'b0;
         nxt_st.poll_req = 1'b1;
         nxt_st.poll_cnt = 16'h0;
         if (sup_hide) begin
            nxt_st.supp_cnt = st_ff.supp_cnt + 16'h1;
         end else begin
            nxt_st.supp_cnt = 16'h0;
            nxt_st.awake_ind = 1'b1;
         end
      end

      // Periodic poll while awake
      if (st_ff.state == EDSC_AWAKE || st_ff.state == EDSC_CHECK) begin
         if (tick) begin
            if (st_ff.poll_cnt >= st_ff.poll_iv) begin
               nxt_st.poll_cnt = 16'h0;
               nxt_st.poll_req = can_sleep;
            end else begin
               nxt_st.poll_cnt = st_ff.poll_cnt + 16'h1;
            end
         end
      end

      // Never asleep unless sleeping allowed
      if (!can_sleep && st_ff.state == EDSC_AWAKE) begin
         nxt_st.low_power = 1'b0;
         nxt_st.awake_ind = 1'b1;
         nxt_st.cts_n = 1'b0;
      end
      if (!st_ff.cts_en) begin
         nxt_st.cts_n = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{mode: RST_MODE, role: RST_ROLE, cts_en: 1'b0, idle_time: RST_IDLE,
                    period: RST_PERIOD, supp: RST_SUPP, poll_iv: RST_POLLIV,
                    state: EDSC_AWAKE, awake_ind: 1'b1, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata          = st_ff.prdata;
   assign pready          = st_ff.pready;
   assign pslverr         = st_ff.pslverr;
   assign poll_req        = st_ff.poll_req;
   assign awake_indicator = st_ff.awake_ind;
   assign cts_n           = st_ff.cts_n;
   assign low_power       = st_ff.low_power;
endmodule
`default_nettype wire

/* edsc_pkg.sv */
package edsc_pkg;
   // Sleep mode selections
   localparam logic [2:0] SLEEP_MODE_OFF    = 3'h0;
   localparam logic [2:0] SLEEP_MODE_PIN    = 3'h1;
   localparam logic [2:0] SLEEP_MODE_CYCLIC = 3'h4;

   // Node roles
   localparam logic [1:0] ROLE_COORD = 2'h0;
   localparam logic [1:0] ROLE_ROUTER = 2'h1;
   localparam logic [1:0] ROLE_END   = 2'h2;

   // Register byte offsets
   localparam logic [7:0] ADDR_MODE    = 8'h00;
   localparam logic [7:0] ADDR_IDLE    = 8'h04;
   localparam logic [7:0] ADDR_PERIOD  = 8'h08;
   localparam logic [7:0] ADDR_SUPP    = 8'h0c;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_POLLIV  = 8'h14;

   // Field positions in the mode register
   localparam int MODE_SEL_LSB  = 0;
   localparam int MODE_ROLE_LSB = 4;
   localparam int MODE_CTS_BIT  = 8;

   // Reset values
   localparam logic [2:0]  RST_MODE    = SLEEP_MODE_OFF;
   localparam logic [1:0]  RST_ROLE    = ROLE_END;
   localparam logic [15:0] RST_IDLE    = 16'h0005;
   localparam logic [15:0] RST_PERIOD  = 16'h0014;
   localparam logic [15:0] RST_SUPP    = 16'h0000;
   localparam logic [15:0] RST_POLLIV  = 16'h0002;

   // Base tick: 1 us at 100 MHz
   localparam int TICK_NS     = 1000;
   localparam int CLK_NS      = 10;
   localparam int TICK_CYCLES = TICK_NS / CLK_NS;

   typedef enum logic [3:0] {
      EDSC_AWAKE    = 4'b0001,
      EDSC_DRAIN    = 4'b0010,
      EDSC_ASLEEP   = 4'b0100,
      EDSC_CHECK    = 4'b1000
   } edsc_state_e;
endpackage

/* edsc_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module edsc_tick
   import edsc_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } edsc_tick_s;

   edsc_tick_s st_ff;
   edsc_tick_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (st_ff.cnt == 8'(TICK_CYCLES - 1)) begin
         nxt_st.cnt = 8'h00;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;
endmodule
`default_nettype wire

/* edsc_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module edsc_sva
   import edsc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        sleep_request_pin,
   input wire logic        xfer_busy,
   input wire logic        poll_req,
   input wire logic        awake_indicator,
   input wire logic        cts_n,
   input wire logic        low_power
);
   logic [8:0] mode_ff;
   wire logic  pin_m = mode_ff[2:0] == SLEEP_MODE_PIN;
   wire logic  can_m = pin_m || mode_ff[2:0] == SLEEP_MODE_CYCLIC;
   // Mode copy taken at the same edge the design takes the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode_ff <= {3'h0, RST_ROLE, 1'b0, RST_MODE};
      else if (psel && penable && pready && pwrite && paddr == ADDR_MODE)
         mode_ff <= pwdata[8:0];
   end
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("late pready");
   property p_off; !low_power && !can_m |=> !low_power; endproperty
   a_off: assert property (p_off) else $error("slept while disabled");
   property p_role; !low_power && mode_ff[5:4] != ROLE_END |=> !low_power; endproperty
   a_role: assert property (p_role) else $error("slept in wrong role");
   property p_drain; $rose(low_power) |-> !$past(xfer_busy); endproperty
   a_drain: assert property (p_drain) else $error("slept mid transfer");
   property p_cts_sl; $rose(low_power) |-> cts_n == mode_ff[8]; endproperty
   a_cts_sl: assert property (p_cts_sl) else $error("cts wrong asleep");
   property p_cts_wk; $fell(low_power) |-> !cts_n; endproperty
   a_cts_wk: assert property (p_cts_wk) else $error("cts high awake");
   property p_ind; $fell(low_power) && pin_m |-> awake_indicator; endproperty
   a_ind: assert property (p_ind) else $error("no wake shown");
   property p_poll; $fell(low_power) |-> ##[0:8] poll_req; endproperty
   a_poll: assert property (p_poll) else $error("no poll");
   property p_pwake; low_power && pin_m && $fell(sleep_request_pin) |-> ##[1:5] !low_power; endproperty
   a_pwake: assert property (p_pwake) else $error("late wake");
   c_pin: cover property ($fell(low_power) && pin_m);
   c_cyc: cover property ($fell(low_power) && !pin_m);
   c_poll: cover property (poll_req && !low_power);
endmodule
bind edsc_top edsc_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .sleep_request_pin, .xfer_busy, .poll_req, .awake_indicator, .cts_n, .low_power);
`default_nettype wire

/* edsc_parent_model.sv */
`timescale 1ns/1ps
`default_nettype none
module edsc_parent_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic poll_req,
   input  wire logic queue_pkt,
   input  wire logic slow,
   output logic      parent_has_data
);
   int held;
   int cnt;
   // Packets wait here until the child polls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 0;
         cnt <= 0;
      end else begin
         held <= held + int'(queue_pkt) - int'(poll_req && held > 0);
         if (poll_req && held > 0)
            cnt <= slow ? 12 : 8;
         else if (cnt > 0)
            cnt <= cnt - 1;
      end
   end
   assign parent_has_data = cnt > 0 && cnt <= 8;
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
   import edsc_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        pin, busy, ser, rad, phd, poll, awk, cts_n, lp, lp_q, qpkt, slow;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, lfsr;
   logic [31:0] regm [6];
   int          mismatches, n_checks, n, k, j, npoll, nshow;
   edsc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sleep_request_pin(pin), .xfer_busy(busy), .serial_activity(ser), .radio_activity(rad),
      .parent_has_data(phd), .poll_req(poll), .awake_indicator(awk), .cts_n, .low_power(lp));
   edsc_parent_model parent (.pclk, .presetn, .poll_req(poll), .queue_pkt(qpkt), .slow,
      .parent_has_data(phd));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      npoll <= npoll + int'(poll === 1'b1);
      nshow <= nshow + int'(lp_q === 1'b1 && lp === 1'b0 && awk === 1'b1);
      lp_q <= lp;
   end
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: word %h not %h", $time, g, e);
      end
   endtask
   task automatic cmp_b(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: flag %b not %b", $time, g, e);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic limit(input int i, input int lim);
      if (i >= lim) begin
         mismatches++;
         $display("Error at %0t: wait ran out", $time);
         close_out;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 9; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      limit(i, 9);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      cmp_b(er, 1'b0);
      regm[a[4:2]] = d & (a == ADDR_MODE ? 32'h137 : 32'hffff);
   endtask
   task automatic rdc(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      cmp_w(rd, regm[a[4:2]]);
      cmp_b(er, 1'b0);
   endtask
   task automatic wlp(input logic v, input int lim);
      for (n = 0; n < lim && lp !== v; n++) @(posedge pclk);
      limit(n, lim);
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
   endtask
   initial begin
      {psel, penable, pwrite, pin, busy, ser, rad, qpkt, slow, presetn} = '0;
      {paddr, pwdata, mismatches, n_checks, npoll, nshow} = '0;
      lfsr = 32'hd5d8ee6d;
      regm = '{32'({RST_ROLE, 1'b0, RST_MODE}), RST_IDLE, RST_PERIOD, RST_SUPP,
               32'({1'b0, 1'b1, 1'b0, EDSC_AWAKE}), RST_POLLIV};
      tick(10);
      presetn <= 1'b1;
      tick(1);
      cmp_b(lp, 1'b0);
      cmp_b(awk, 1'b1);
      cmp_b(cts_n, 1'b0);
      for (k = 0; k < 24; k += 4) begin
         rdc(8'(k));
      end
      apb(1'b1, ADDR_STATUS, 32'hffffffff);
      cmp_b(er, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      cmp_b(er, 1'b1);
      for (k = 4; k < 24; k += 4) begin
         lfsr = nx(lfsr);
         if (k != 16) wr(8'(k), lfsr);
         if (k != 16) rdc(8'(k));
      end
      wr(ADDR_IDLE, 32'h6);
      wr(ADDR_PERIOD, 32'h3);
      wr(ADDR_SUPP, 32'h0);
      wr(ADDR_POLLIV, 32'h2);
      pin <= 1'b1;
      tick(700);
      cmp_b(lp, 1'b0);
      wr(ADDR_MODE, 32'h101);
      tick(700);
      cmp_b(lp, 1'b0);
      busy <= 1'b1;
      wr(ADDR_MODE, 32'h121);
      tick(50);
      cmp_b(lp, 1'b0);
      busy <= 1'b0;
      wlp(1'b1, 20);
      cmp_b(cts_n, 1'b1);
      cmp_b(awk, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp_w(rd, 32'({1'b1, 1'b0, 1'b1, EDSC_ASLEEP}));
      {ser, rad, qpkt} <= 3'h7;
      tick(1);
      qpkt <= 1'b0;
      tick(700);
      cmp_b(lp, 1'b1);
      {ser, rad, pin} <= 3'h0;
      j = npoll;
      wlp(1'b0, 10);
      cmp_b(cts_n, 1'b0);
      cmp_b(awk, 1'b1);
      tick(450);
      cmp_b(npoll - j >= 2, 1'b1);
      wr(ADDR_MODE, 32'h024);
      ser <= 1'b1;
      tick(1);
      ser <= 1'b0;
      wlp(1'b1, 1000);
      cmp_b(n >= 500 && n <= 720, 1'b1);
      wlp(1'b0, 600);
      cmp_b(n >= 200 && n <= 410, 1'b1);
      wlp(1'b1, 1000);
      {slow, qpkt} <= 2'h3;
      tick(1);
      qpkt <= 1'b0;
      wlp(1'b0, 600);
      j = npoll;
      for (k = 0; k < 12; k++) begin
         rad <= 1'b1;
         tick(1);
         rad <= 1'b0;
         tick(99);
      end
      cmp_b(lp, 1'b0);
      cmp_b(npoll - j >= 3, 1'b1);
      wr(ADDR_SUPP, 32'h2);
      j = nshow;
      for (k = 0; k < 4; k++) begin
         wlp(1'b1, 1000);
         wlp(1'b0, 600);
      end
      tick(2);
      cmp_w(32'(nshow - j), 32'h2);
      close_out;
   end
   initial begin
      #1000000;
      limit(1, 0);
   end
endmodule
`default_nettype wire
